/* bbd_decoder.sv */
/*
 Fetch, decode and execute of the relative branch, bit test and branch, bit set and clear,
 control and long jump and call instruction groups.
 Assumes program and data memories answer combinationally to the address driven in the same
 cycle, and that the interrupt logic supplies the saved flags for the interrupt exit.
*/
// How it works
// - Short branches test carry/zero, two cycles, flags kept.
// - Short displacement is five-bit signed, -15..+16.
// - Bit-clear test reads byte, branches on 0, five cycles.
// - Bit-high test branches on 1, five cycles.
// - Tested bit goes to carry; zero kept.
// - Bit test displacement is eight-bit signed, -126..+129.
// - Set/clear one bit, two bytes, four cycles.
// - Control ops two cycles; only interrupt exit changes flags.
// - Watchdog selected turns stop into wait.
// - Long jump and call reach 12-bit target, four cycles.
// - Direction bit: 0 forward, 1 backward.
`default_nettype none

module bbd_decoder #(
    parameter int STACK_DEPTH = 6
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    input  wire logic                      watchdog_sel,
    input  wire logic [bbd_pkg::DATA_W-1:0] prog_data,
    input  wire logic [bbd_pkg::DATA_W-1:0] data_rd_data,
    input  wire logic                      saved_zero,
    input  wire logic                      saved_carry,
    output logic      [bbd_pkg::PC_W-1:0]   prog_addr,
    output logic      [bbd_pkg::DATA_W-1:0] data_addr,
    output logic                           data_wr_en,
    output logic      [bbd_pkg::DATA_W-1:0] data_wr_data,
    output logic                           flag_zero,
    output logic                           flag_carry,
    output logic                           stop_req,
    output logic                           wait_req,
    output logic                           instr_done
);

    bbd_pkg::bbd_state_e        state;
    bbd_pkg::bbd_state_e        next_state;
    logic [bbd_pkg::PC_W-1:0]   pc;
    logic [bbd_pkg::PC_W-1:0]   next_pc;
    logic [bbd_pkg::PC_W-1:0]   next_prog_addr;
    logic [bbd_pkg::DATA_W-1:0] opcode;
    logic [bbd_pkg::DATA_W-1:0] next_opcode;
    logic [bbd_pkg::DATA_W-1:0] disp;
    logic [bbd_pkg::DATA_W-1:0] next_disp;
    logic [2:0]                 step;
    logic [2:0]                 next_step;
    logic                       bit_seen;
    logic                       next_bit_seen;
    logic [bbd_pkg::DATA_W-1:0] next_data_addr;
    logic                       next_data_wr_en;
    logic [bbd_pkg::DATA_W-1:0] next_data_wr_data;
    logic                       next_flag_zero;
    logic                       next_flag_carry;
    logic                       next_stop_req;
    logic                       next_wait_req;
    logic                       next_instr_done;
    logic                       stack_push;
    logic                       stack_pop;
    logic [bbd_pkg::PC_W-1:0]   stack_top;

    logic [2:0]                 grp;
    logic [2:0]                 sel;
    logic [2:0]                 last_step;
    logic                       rel_taken;
    logic [bbd_pkg::PC_W-1:0]   rel_target;
    logic [bbd_pkg::PC_W-1:0]   bt_target;
    logic [bbd_pkg::PC_W-1:0]   ext_target;

    ////////////////////////////////////////////////////////////////////////////////////////////////

    // Holds the return addresses of calls.
    bbd_return_stack #(
        .DEPTH (STACK_DEPTH)
    ) u_return_stack (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .push      (stack_push),
        .pop       (stack_pop),
        .push_addr (pc + bbd_pkg::LEN_TWO),
        .top_addr  (stack_top)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////

    // Decodes the latched opcode into group, selector, length and targets.
    always_comb begin
        grp = opcode[7:bbd_pkg::OPC_GRP_LSB];
        sel = opcode[2:0];
        unique case (grp)
            bbd_pkg::GRP_BIT_TEST: last_step = bbd_pkg::CYC_BIT_TEST - 3'h1;
            bbd_pkg::GRP_BIT_RW:   last_step = bbd_pkg::CYC_BIT_RW - 3'h1;
            bbd_pkg::GRP_EXT:      last_step = bbd_pkg::CYC_EXT - 3'h1;
            bbd_pkg::GRP_CTRL:     last_step = bbd_pkg::CYC_CTRL - 3'h1;
            default:               last_step = bbd_pkg::CYC_REL - 3'h1;
        endcase
        unique case (grp)
            bbd_pkg::GRP_REL_CARRY:    rel_taken = flag_carry;
            bbd_pkg::GRP_REL_NO_CARRY: rel_taken = !flag_carry;
            bbd_pkg::GRP_REL_ZERO:     rel_taken = flag_zero;
            bbd_pkg::GRP_REL_NONZERO:  rel_taken = !flag_zero;
            default:                   rel_taken = 1'b0;
        endcase
        // Bit 4 set gives a negative offset, so the span is -15 to +16.
        rel_target = pc + bbd_pkg::REL_BASE + {{7{opcode[bbd_pkg::OPC_DIR_BIT]}}, opcode[4:0]};
        bt_target  = pc + bbd_pkg::BT_BASE + {{4{disp[7]}}, disp};
        ext_target = {opcode[3:0], disp};
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////

    // Sequences each instruction step by step and commits it on its last step.
    always_comb begin
        next_state        = state;
        next_pc           = pc;
        next_prog_addr    = prog_addr;
        next_opcode       = opcode;
        next_disp         = disp;
        next_step         = step;
        next_bit_seen     = bit_seen;
        next_data_addr    = data_addr;
        next_data_wr_en   = 1'b0;
        next_data_wr_data = data_wr_data;
        next_flag_zero    = flag_zero;
        next_flag_carry   = flag_carry;
        next_stop_req     = 1'b0;
        next_wait_req     = 1'b0;
        next_instr_done   = 1'b0;
        stack_push        = 1'b0;
        stack_pop         = 1'b0;
        unique case (state)
            bbd_pkg::ST_FETCH: begin
                next_opcode    = prog_data;
                next_prog_addr = pc + bbd_pkg::LEN_ONE;
                next_step      = 3'h1;
                next_state     = bbd_pkg::ST_EXEC;
            end
            bbd_pkg::ST_EXEC: begin
                next_step = step + 3'h1;
                if (step == bbd_pkg::STEP_OP1) begin
                    if (grp == bbd_pkg::GRP_BIT_TEST || grp == bbd_pkg::GRP_BIT_RW) begin
                        next_data_addr = prog_data;
                        next_prog_addr = pc + bbd_pkg::LEN_TWO;
                    end else if (grp == bbd_pkg::GRP_EXT) begin
                        next_disp = prog_data;
                    end
                end
                if (step == bbd_pkg::STEP_OP2 && grp == bbd_pkg::GRP_BIT_TEST) begin
                    next_disp = prog_data;
                end
                if (step == bbd_pkg::STEP_DATA && grp == bbd_pkg::GRP_BIT_RW) begin
                    next_data_wr_en   = 1'b1;
                    next_data_wr_data = data_rd_data;
                    next_data_wr_data[sel] = opcode[bbd_pkg::OPC_SEL_BIT];
                end
                if (step == bbd_pkg::STEP_TEST && grp == bbd_pkg::GRP_BIT_TEST) begin
                    next_bit_seen = data_rd_data[sel];
                end
                if (step == last_step) begin
                    next_state      = bbd_pkg::ST_FETCH;
                    next_step       = 3'h0;
                    next_instr_done = 1'b1;
                    unique case (grp)
                        bbd_pkg::GRP_BIT_TEST: begin
                            next_flag_carry = bit_seen;
                            if (bit_seen == opcode[bbd_pkg::OPC_SEL_BIT]) begin
                                next_pc = bt_target;
                            end else begin
                                next_pc = pc + bbd_pkg::LEN_THREE;
                            end
                        end
                        bbd_pkg::GRP_BIT_RW: begin
                            next_pc = pc + bbd_pkg::LEN_TWO;
                        end
                        bbd_pkg::GRP_EXT: begin
                            next_pc    = ext_target;
                            stack_push = opcode[bbd_pkg::OPC_SEL_BIT];
                        end
                        bbd_pkg::GRP_CTRL: begin
                            next_pc = pc + bbd_pkg::LEN_ONE;
                            unique case (sel)
                                bbd_pkg::CTL_SUB_EXIT: begin
                                    next_pc   = stack_top;
                                    stack_pop = 1'b1;
                                end
                                bbd_pkg::CTL_INT_EXIT: begin
                                    next_pc         = stack_top;
                                    stack_pop       = 1'b1;
                                    next_flag_zero  = saved_zero;
                                    next_flag_carry = saved_carry;
                                end
                                bbd_pkg::CTL_STOP: begin
                                    next_stop_req = !watchdog_sel;
                                    next_wait_req = watchdog_sel;
                                end
                                bbd_pkg::CTL_WAIT: begin
                                    next_wait_req = 1'b1;
                                end
                                default: begin
                                end
                            endcase
                        end
                        default: begin
                            next_pc = rel_taken ? rel_target : pc + bbd_pkg::LEN_ONE;
                        end
                    endcase
                    next_prog_addr = next_pc;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state        <= bbd_pkg::ST_FETCH;
            pc           <= bbd_pkg::PC_RESET;
            prog_addr    <= bbd_pkg::PC_RESET;
            opcode       <= 8'h00;
            disp         <= 8'h00;
            step         <= 3'h0;
            bit_seen     <= 1'b0;
            data_addr    <= 8'h00;
            data_wr_en   <= 1'b0;
            data_wr_data <= 8'h00;
            flag_zero    <= 1'b0;
            flag_carry   <= 1'b0;
            stop_req     <= 1'b0;
            wait_req     <= 1'b0;
            instr_done   <= 1'b0;
        end else begin
            state        <= next_state;
            pc           <= next_pc;
            prog_addr    <= next_prog_addr;
            opcode       <= next_opcode;
            disp         <= next_disp;
            step         <= next_step;
            bit_seen     <= next_bit_seen;
            data_addr    <= next_data_addr;
            data_wr_en   <= next_data_wr_en;
            data_wr_data <= next_data_wr_data;
            flag_zero    <= next_flag_zero;
            flag_carry   <= next_flag_carry;
            stop_req     <= next_stop_req;
            wait_req     <= next_wait_req;
            instr_done   <= next_instr_done;
        end
    end

endmodule : bbd_decoder

`default_nettype wire

/* bbd_decoder_sva.sv */
/*
 Concurrent checks on the ports of the branch, bit and control decoder.
 Assumes the bench keeps watchdog_sel steady around a stop instruction.
*/
`default_nettype none

module bbd_decoder_chk (
    input wire logic                        ref_clk,
    input wire logic                        rst,
    input wire logic                        watchdog_sel,
    input wire logic [bbd_pkg::DATA_W-1:0]  prog_data,
    input wire logic [bbd_pkg::PC_W-1:0]    prog_addr,
    input wire logic                        data_wr_en,
    input wire logic                        flag_zero,
    input wire logic                        flag_carry,
    input wire logic                        stop_req,
    input wire logic                        wait_req,
    input wire logic                        instr_done
);
    logic        rel_take;
    logic [11:0] rel_tgt;

    assign rel_take = prog_data[6] ? (flag_zero ^ prog_data[5]) : (flag_carry ^ prog_data[5]);
    assign rel_tgt  = prog_addr + 12'h001 + {{7{prog_data[4]}}, prog_data[4:0]};

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    a_rel_target: assert property (instr_done && !prog_data[7] |=> ##1
        prog_addr == ($past(rel_take, 2) ? $past(rel_tgt, 2) : $past(prog_addr, 2) + 12'h001))
        else $error("short branch target wrong");
    a_rel_flags_kept: assert property (instr_done && !prog_data[7] |=> ##1
        {flag_zero, flag_carry} == $past({flag_zero, flag_carry}, 2)) else $error("branch changed flags");
    a_two_cycle_ops: assert property (instr_done && (!prog_data[7] || prog_data[7:5] == 3'h7)
        |=> !instr_done ##1 instr_done) else $error("two cycle length wrong");
    a_bit_test_len: assert property (instr_done && prog_data[7:5] == 3'h4
        |=> !instr_done [*4] ##1 instr_done) else $error("bit test length wrong");
    a_four_cycle_ops: assert property (instr_done && (prog_data[7:5] == 3'h5 || prog_data[7:5] == 3'h6)
        |=> !instr_done [*3] ##1 instr_done) else $error("four cycle length wrong");
    a_ext_target: assert property (instr_done && prog_data[7:5] == 3'h6 |=> ##3
        prog_addr == {$past(prog_data[3:0], 4), $past(prog_data, 3)}) else $error("long target wrong");
    a_wr_then_done: assert property (data_wr_en |=> !data_wr_en && instr_done)
        else $error("write pulse misplaced");
    a_flags_at_done: assert property ($changed({flag_zero, flag_carry}) |-> instr_done)
        else $error("flags changed mid instruction");
    a_stop_swap: assert property (instr_done && prog_data == 8'hE3 |=> ##1
        (watchdog_sel ? (wait_req && !stop_req) : (stop_req && !wait_req))) else $error("stop request wrong");
    a_stop_gated: assert property (stop_req |-> instr_done && !watchdog_sel)
        else $error("stop with watchdog");
    a_wait_on_done: assert property (wait_req |-> instr_done)
        else $error("wait request misplaced");
endmodule : bbd_decoder_chk

bind bbd_decoder bbd_decoder_chk i_bbd_decoder_chk (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .watchdog_sel (watchdog_sel),
    .prog_data    (prog_data),
    .prog_addr    (prog_addr),
    .data_wr_en   (data_wr_en),
    .flag_zero    (flag_zero),
    .flag_carry   (flag_carry),
    .stop_req     (stop_req),
    .wait_req     (wait_req),
    .instr_done   (instr_done)
);

`default_nettype wire

/* bbd_pkg.sv */
/*
 Constants for the branch, bit and control instruction decoder: opcode fields, group codes,
 cycle counts, instruction lengths and displacement bases.
 Assumes the core fetches one program byte per clock from a 12-bit program space.
*/
`default_nettype none

package bbd_pkg;

    localparam int PC_W   = 12;
    localparam int DATA_W = 8;

    // Opcode field positions.
    localparam int OPC_GRP_LSB = 5;
    localparam int OPC_SEL_BIT = 4;
    localparam int OPC_DIR_BIT = 4;

    // Instruction groups held in opcode bits 7..5.
    localparam logic [2:0] GRP_REL_CARRY    = 3'h0;
    localparam logic [2:0] GRP_REL_NO_CARRY = 3'h1;
    localparam logic [2:0] GRP_REL_ZERO     = 3'h2;
    localparam logic [2:0] GRP_REL_NONZERO  = 3'h3;
    localparam logic [2:0] GRP_BIT_TEST     = 3'h4;
    localparam logic [2:0] GRP_BIT_RW       = 3'h5;
    localparam logic [2:0] GRP_EXT          = 3'h6;
    localparam logic [2:0] GRP_CTRL         = 3'h7;

    // Control codes held in opcode bits 2..0 of the control group.
    localparam logic [2:0] CTL_NOP      = 3'h0;
    localparam logic [2:0] CTL_SUB_EXIT = 3'h1;
    localparam logic [2:0] CTL_INT_EXIT = 3'h2;
    localparam logic [2:0] CTL_STOP     = 3'h3;
    localparam logic [2:0] CTL_WAIT     = 3'h4;

    // Cycles per instruction.
    localparam logic [2:0] CYC_REL      = 3'h2;
    localparam logic [2:0] CYC_BIT_TEST = 3'h5;
    localparam logic [2:0] CYC_BIT_RW   = 3'h4;
    localparam logic [2:0] CYC_EXT      = 3'h4;
    localparam logic [2:0] CYC_CTRL     = 3'h2;

    // Steps at which operands are fetched and data is sampled.
    localparam logic [2:0] STEP_OP1  = 3'h1;
    localparam logic [2:0] STEP_OP2  = 3'h2;
    localparam logic [2:0] STEP_DATA = 3'h2;
    localparam logic [2:0] STEP_TEST = 3'h3;

    // Instruction lengths in bytes.
    localparam logic [11:0] LEN_ONE   = 12'h001;
    localparam logic [11:0] LEN_TWO   = 12'h002;
    localparam logic [11:0] LEN_THREE = 12'h003;

    // Base added to the signed displacement, counted from the instruction address.
    localparam logic [11:0] REL_BASE = 12'h001;
    localparam logic [11:0] BT_BASE  = 12'h002;

    localparam logic [11:0] PC_RESET = 12'h000;

    typedef enum logic {
        ST_FETCH,
        ST_EXEC
    } bbd_state_e;

endpackage : bbd_pkg

`default_nettype wire

/* bbd_return_stack.sv */
/*
 Hardware return stack of program addresses, held in flip-flops.
 Assumes push and pop never arrive in the same cycle; an overflow overwrites the oldest entry.
*/
`default_nettype none

module bbd_return_stack #(
    parameter int DEPTH = 6
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    input  wire logic                    push,
    input  wire logic                    pop,
    input  wire logic [bbd_pkg::PC_W-1:0] push_addr,
    output logic      [bbd_pkg::PC_W-1:0] top_addr
);

    localparam int PTR_W = $clog2(DEPTH);

    logic [bbd_pkg::PC_W-1:0] entry      [DEPTH];
    logic [bbd_pkg::PC_W-1:0] next_entry [DEPTH];
    logic [PTR_W-1:0]         ptr;
    logic [PTR_W-1:0]         next_ptr;
    logic [bbd_pkg::PC_W-1:0] next_top_addr;

    ////////////////////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_entry = entry;
        next_ptr   = ptr;
        if (push) begin
            next_ptr = (ptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(ptr + 1'b1);
            next_entry[next_ptr] = push_addr;
        end else if (pop) begin
            next_ptr = (ptr == '0) ? PTR_W'(DEPTH - 1) : PTR_W'(ptr - 1'b1);
        end
        next_top_addr = next_entry[next_ptr];
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                entry[i] <= bbd_pkg::PC_RESET;
            end
            ptr      <= '0;
            top_addr <= bbd_pkg::PC_RESET;
        end else begin
            entry    <= next_entry;
            ptr      <= next_ptr;
            top_addr <= next_top_addr;
        end
    end

endmodule : bbd_return_stack

`default_nettype wire

/* test_bbd_decoder.sv */
/*
 Self-checking bench for the branch, bit and control decoder.
 Assumes combinational program and data memories modelled here and one 100 MHz clock.
*/
`default_nettype none

module test_bbd_decoder;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk      = 1'b0;
    logic        rst          = 1'b1;
    logic        watchdog_sel = 1'b0;
    logic        saved_zero   = 1'b0;
    logic        saved_carry  = 1'b0;
    logic        wd_q         = 1'b0;
    logic        sz_q         = 1'b0;
    logic        sc_q         = 1'b0;
    logic [7:0]  prog [0:4095];
    logic [7:0]  dmem [0:255];
    logic [7:0]  prog_data;
    logic [7:0]  data_rd_data;
    logic [7:0]  data_addr;
    logic [7:0]  data_wr_data;
    logic [11:0] prog_addr;
    logic        data_wr_en;
    logic        flag_zero;
    logic        flag_carry;
    logic        stop_req;
    logic        wait_req;
    logic        instr_done;
    logic [11:0] pc           = 12'h000;
    logic        ez           = 1'b0;
    logic        ec           = 1'b0;
    int          fails        = 0;
    int          cmp_count    = 0;
    int          cycles       = 0;

    always #5 ref_clk = ~ref_clk;

    assign prog_data    = prog[prog_addr];
    assign data_rd_data = dmem[data_addr];

    always @(posedge ref_clk) begin
        watchdog_sel <= wd_q;
        saved_zero   <= sz_q;
        saved_carry  <= sc_q;
        if (data_wr_en === 1'b1) begin
            dmem[data_addr] <= data_wr_data;
        end
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 2000) begin
            fails++;
            give_verdict();
        end
    end

    bbd_decoder i_bbd_decoder (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .watchdog_sel (watchdog_sel),
        .prog_data    (prog_data),
        .data_rd_data (data_rd_data),
        .saved_zero   (saved_zero),
        .saved_carry  (saved_carry),
        .prog_addr    (prog_addr),
        .data_addr    (data_addr),
        .data_wr_en   (data_wr_en),
        .data_wr_data (data_wr_data),
        .flag_zero    (flag_zero),
        .flag_carry   (flag_carry),
        .stop_req     (stop_req),
        .wait_req     (wait_req),
        .instr_done   (instr_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic chk_flags;
        check({10'h000, flag_zero, flag_carry}, {10'h000, ez, ec});
    endtask : chk_flags

    // Places one instruction at pc, counts its cycles and checks the next fetch address.
    task automatic exec(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                        input int cyc, input logic [11:0] nxt);
        int n;
        n = 0;
        prog[pc] = b0;
        prog[pc + 12'h001] = b1;
        prog[pc + 12'h002] = b2;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (instr_done !== 1'b1 && n < 12);
        check(12'(n), 12'(cyc));
        check(prog_addr, nxt);
        pc = nxt;
    endtask : exec

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_branch;
        logic [4:0]  d;
        logic        take;
        logic [11:0] tgt;
        for (int g = 0; g < 4; g++) begin
            for (int k = 0; k < 2; k++) begin
                d = k ? 5'h10 : 5'h0F;
                take = g[1] ? (ez ^ g[0]) : (ec ^ g[0]);
                tgt = take ? pc + 12'h001 + {{7{d[4]}}, d} : pc + 12'h001;
                exec({g[2:0], d}, 8'h00, 8'h00, 2, tgt);
                chk_flags();
            end
        end
    endtask : t_branch

    task automatic t_bit_test;
        logic [7:0]  ee;
        logic        bitv;
        logic [11:0] tgt;
        dmem[8'h20] = 8'hA5;
        for (int s = 0; s < 2; s++) begin
            for (int b = 0; b < 2; b++) begin
                ee = b ? 8'h80 : 8'h7F;
                bitv = dmem[8'h20][b];
                tgt = (bitv == s[0]) ? pc + 12'h002 + {{4{ee[7]}}, ee} : pc + 12'h003;
                exec({3'h4, s[0], 1'b0, b[2:0]}, 8'h20, ee, 5, tgt);
                ec = bitv;
                chk_flags();
                check({4'h0, data_addr}, 12'h020);
            end
        end
    endtask : t_bit_test

    task automatic t_bit_rw;
        dmem[8'h31] = 8'h0F;
        exec(8'hB7, 8'h31, 8'h00, 4, pc + 12'h002);
        check({4'h0, dmem[8'h31]}, 12'h08F);
        exec(8'hA0, 8'h31, 8'h00, 4, pc + 12'h002);
        check({4'h0, dmem[8'h31]}, 12'h08E);
        chk_flags();
    endtask : t_bit_rw

    task automatic t_jump_call;
        exec(8'hCA, 8'hBC, 8'h00, 4, 12'hABC);
        exec(8'hD5, 8'hE0, 8'h00, 4, 12'h5E0);
        exec(8'hE1, 8'h00, 8'h00, 2, 12'hABE);
        chk_flags();
        sz_q = 1'b1;
        sc_q = 1'b1;
        exec(8'hD4, 8'h00, 8'h00, 4, 12'h400);
        exec(8'hE2, 8'h00, 8'h00, 2, 12'hAC0);
        ez = 1'b1;
        ec = 1'b1;
        chk_flags();
    endtask : t_jump_call

    task automatic t_control;
        exec(8'hE0, 8'h00, 8'h00, 2, pc + 12'h001);
        check({10'h000, stop_req, wait_req}, 12'h000);
        exec(8'hE3, 8'h00, 8'h00, 2, pc + 12'h001);
        check({10'h000, stop_req, wait_req}, 12'h002);
        exec(8'hE4, 8'h00, 8'h00, 2, pc + 12'h001);
        check({10'h000, stop_req, wait_req}, 12'h001);
        wd_q = 1'b1;
        exec(8'hE0, 8'h00, 8'h00, 2, pc + 12'h001);
        exec(8'hE3, 8'h00, 8'h00, 2, pc + 12'h001);
        check({10'h000, stop_req, wait_req}, 12'h001);
        chk_flags();
        wd_q = 1'b0;
    endtask : t_control

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        check(prog_addr, 12'h000);
        chk_flags();
        exec(8'hC4, 8'h00, 8'h00, 4, 12'h400);
        t_branch();
        t_bit_test();
        t_bit_rw();
        t_jump_call();
        t_control();
        t_branch();
        give_verdict();
    end
endmodule : test_bbd_decoder

`default_nettype wire
